// ---- pc_sp_hazard_regs.vh ----
`ifndef PC_SP_HAZARD_REGS_VH
`define PC_SP_HAZARD_REGS_VH
// instruction classes presented by the decoder
`define OP_OTHER 4'h0
`define OP_TWO_OPERAND_EXT 4'h1
`define OP_ADD_ADDR_IMM 4'h2
`define OP_SUB_ADDR_IMM 4'h3
`define OP_CMP_ADDR_IMM 4'h4
`define OP_MOVE_ADDR_IMM 4'h5
`define OP_PUSH_EXT_ADDR 4'h6
`define OP_PUSH 4'h7
`define OP_CALL_ADDR 4'h8
`define OP_LOW_POWER_ENTRY 4'h9
`define OP_REG_REG_20BIT 4'hA
// addressing modes
`define MODE_REGISTER 3'h0
`define MODE_INDEXED 3'h1
`define MODE_SYMBOLIC 3'h2
`define MODE_ABSOLUTE 3'h3
`define MODE_INDIRECT 3'h4
`define MODE_INDIRECT_INC 3'h5
`define MODE_IMMEDIATE 3'h6
// register numbers
`define REG_PC 4'h0
`define REG_SP 4'h1
// byte counts and offsets
`define ADDR_W 20
`define OPCODE_BYTES_ADDR_IMM 20'h0_0004
`define OPCODE_BYTES_SHORT 20'h0_0002
`define STACK_WORD_BYTES 20'h0_0004
`define RESET_PC 20'h0_0000
`define RESET_SP 20'h0_0000
`define INDEX_SIGN_BIT 15
`endif

// ---- hist_reg.v ----
`timescale 1ns/1ps
// one-deep history of the previous retired instruction
module hist_reg
(
   input wire clk_in,
   input wire rst_in,
   input wire load_in,
   input wire [7:0] d_in,
   output reg [7:0] q_out
);
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         q_out <= 8'h00;
      else if (load_in)
         q_out <= d_in;
   end
endmodule

// ---- cpu_pc_sp_hazard_model.v ----
`timescale 1ns/1ps
`include "pc_sp_hazard_regs.vh"
module cpu_pc_sp_hazard_model
(
   input wire CLK_IN,
   input wire RST_IN,
   input wire DEFECT_EN_IN,
   input wire INSN_VALID_IN,
   input wire [3:0] INSN_CLASS_IN,
   input wire [2:0] SRC_MODE_IN,
   input wire [2:0] DST_MODE_IN,
   input wire [3:0] SRC_REG_IN,
   input wire [3:0] DST_REG_IN,
   input wire [19:0] OPERAND_IN,
   input wire [19:0] MEM_WORD_IN,
   input wire [19:0] PC_IN,
   input wire NMI_PENDING_IN,
   input wire NMI_ENTRY_IN,
   output reg [19:0] PC_OUT,
   output reg [19:0] SP_OUT,
   output reg [19:0] PUSH_DATA_OUT,
   output reg PUSH_VALID_OUT,
   output reg WIDE_EXEC_OUT,
   output reg FAULT_OUT
);
   wire [7:0] prev_q;
   wire [7:0] prev_d;
   reg [19:0] pc_nxt;
   reg [19:0] sp_nxt;
   reg [19:0] push_nxt;
   reg push_v_nxt;
   reg wide_nxt;
   reg fault_nxt;
   reg lpm_armed_r;
   reg lpm_armed_nxt;
   reg wide_pending_r;
   reg wide_pending_nxt;
   reg [19:0] idx;
   wire prev_wb;
   wire prev_mem_push;
   wire this_pc_mod;
   wire defect;

   function [19:0] sext16;
      input [19:0] v;
      begin
         sext16 = {{4{v[`INDEX_SIGN_BIT]}}, v[`INDEX_SIGN_BIT:0]};
      end
   endfunction

   function is_mem_mode;
      input [2:0] m;
      begin
         is_mem_mode = (m == `MODE_ABSOLUTE) || (m == `MODE_SYMBOLIC) || (m == `MODE_INDEXED) ||
                       (m == `MODE_INDIRECT) || (m == `MODE_INDIRECT_INC);
      end
   endfunction

   assign defect = DEFECT_EN_IN;
   // history: bit7 wb-type, bit6 memory-source push
   assign prev_d = {(INSN_CLASS_IN == `OP_TWO_OPERAND_EXT) && (SRC_MODE_IN == `MODE_REGISTER) &&
                    ((DST_MODE_IN == `MODE_INDEXED) || (DST_MODE_IN == `MODE_ABSOLUTE) ||
                     (DST_MODE_IN == `MODE_SYMBOLIC)),
                    ((INSN_CLASS_IN == `OP_PUSH) || (INSN_CLASS_IN == `OP_PUSH_EXT_ADDR)) &&
                    is_mem_mode(SRC_MODE_IN),
                    6'h00};
   assign prev_wb = prev_q[7];
   assign prev_mem_push = prev_q[6];
   assign this_pc_mod = (INSN_CLASS_IN == `OP_TWO_OPERAND_EXT) && (DST_REG_IN == `REG_PC) &&
                        ((SRC_MODE_IN == `MODE_INDIRECT) || (SRC_MODE_IN == `MODE_INDIRECT_INC) ||
                         (SRC_MODE_IN == `MODE_INDEXED));

   hist_reg u_hist
   (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .load_in(INSN_VALID_IN),
      .d_in(prev_d),
      .q_out(prev_q)
   );

   always @*
   begin
      pc_nxt = PC_OUT;
      sp_nxt = SP_OUT;
      push_nxt = PUSH_DATA_OUT;
      push_v_nxt = 1'b0;
      wide_nxt = 1'b0;
      fault_nxt = 1'b0;
      lpm_armed_nxt = lpm_armed_r;
      wide_pending_nxt = wide_pending_r;
      idx = 20'h0_0000;
      if (INSN_VALID_IN)
      begin
         lpm_armed_nxt = 1'b0;
         if (wide_pending_r && NMI_ENTRY_IN)
         begin
            wide_nxt = 1'b1;
            wide_pending_nxt = 1'b0;
         end
         else if (NMI_ENTRY_IN)
            wide_pending_nxt = 1'b0;
         case (INSN_CLASS_IN)
            `OP_TWO_OPERAND_EXT:
            begin
               if (this_pc_mod)
               begin
                  if (defect && prev_wb)
                     fault_nxt = 1'b1;
                  else
                     pc_nxt = MEM_WORD_IN;
               end
            end
            `OP_ADD_ADDR_IMM, `OP_SUB_ADDR_IMM, `OP_CMP_ADDR_IMM:
            begin
               if (DST_REG_IN == `REG_PC)
               begin
                  // PC base counts only 2 opcode bytes when defective
                  idx = PC_IN + (defect ? `OPCODE_BYTES_SHORT : `OPCODE_BYTES_ADDR_IMM);
                  if (INSN_CLASS_IN == `OP_ADD_ADDR_IMM)
                     pc_nxt = idx + OPERAND_IN;
                  else if (INSN_CLASS_IN == `OP_SUB_ADDR_IMM)
                     pc_nxt = idx - OPERAND_IN;
               end
            end
            `OP_MOVE_ADDR_IMM:
            begin
               if (DST_REG_IN == `REG_PC)
                  pc_nxt = OPERAND_IN;
            end
            `OP_PUSH_EXT_ADDR:
            begin
               push_v_nxt = 1'b1;
               push_nxt = MEM_WORD_IN;
               if (defect && (SRC_MODE_IN == `MODE_INDIRECT_INC) && (SRC_REG_IN == `REG_SP))
                  sp_nxt = MEM_WORD_IN;
               else
                  sp_nxt = SP_OUT - `STACK_WORD_BYTES;
            end
            `OP_PUSH:
            begin
               push_v_nxt = 1'b1;
               push_nxt = MEM_WORD_IN;
               sp_nxt = SP_OUT - `OPCODE_BYTES_SHORT;
            end
            `OP_CALL_ADDR:
            begin
               push_v_nxt = 1'b1;
               sp_nxt = SP_OUT - `STACK_WORD_BYTES;
               if ((SRC_MODE_IN == `MODE_REGISTER) && (SRC_REG_IN == `REG_PC))
               begin
                  push_nxt = PC_IN + (defect ? `OPCODE_BYTES_SHORT : `OPCODE_BYTES_ADDR_IMM);
                  pc_nxt = PC_IN + `OPCODE_BYTES_ADDR_IMM;
               end
               else
               begin
                  push_nxt = PC_IN + `OPCODE_BYTES_ADDR_IMM;
                  if (SRC_MODE_IN == `MODE_INDEXED)
                  begin
                     if (defect && (SRC_REG_IN == `REG_SP) && prev_mem_push)
                        idx = {4'h0, OPERAND_IN[`INDEX_SIGN_BIT:0]};
                     else
                        idx = sext16(OPERAND_IN);
                     pc_nxt = MEM_WORD_IN + idx;
                  end
                  else
                     pc_nxt = MEM_WORD_IN;
               end
            end
            `OP_LOW_POWER_ENTRY:
            begin
               if (SRC_MODE_IN == `MODE_INDEXED && NMI_PENDING_IN)
                  lpm_armed_nxt = 1'b1;
            end
            `OP_REG_REG_20BIT:
            begin
               if (defect && lpm_armed_r)
                  wide_pending_nxt = 1'b1;
            end
            default:
            begin
               pc_nxt = PC_OUT;
            end
         endcase
      end
   end

   always @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         PC_OUT <= `RESET_PC;
         SP_OUT <= `RESET_SP;
         PUSH_DATA_OUT <= 20'h0_0000;
         PUSH_VALID_OUT <= 1'b0;
         WIDE_EXEC_OUT <= 1'b0;
         FAULT_OUT <= 1'b0;
         lpm_armed_r <= 1'b0;
         wide_pending_r <= 1'b0;
      end
      else
      begin
         PC_OUT <= pc_nxt;
         SP_OUT <= sp_nxt;
         PUSH_DATA_OUT <= push_nxt;
         PUSH_VALID_OUT <= push_v_nxt;
         WIDE_EXEC_OUT <= wide_nxt;
         FAULT_OUT <= fault_nxt;
         lpm_armed_r <= lpm_armed_nxt;
         wide_pending_r <= wide_pending_nxt;
      end
   end
endmodule

// ---- prog_mem_model.sv ----
`timescale 1ns/1ps
// program memory: every read returns a word derived from its address
module prog_mem_model
(
   input wire [19:0] addr_in,
   output wire [19:0] word_out
);
   assign word_out = addr_in ^ 20'h5_A5A5;
endmodule

// ---- pc_sp_checker_sva.sv ----
`timescale 1ns/1ps
`include "pc_sp_hazard_regs.vh"
module pc_sp_checker
(
   input wire CLK_IN,
   input wire RST_IN,
   input wire DEFECT_EN_IN,
   input wire INSN_VALID_IN,
   input wire [3:0] INSN_CLASS_IN,
   input wire [2:0] SRC_MODE_IN,
   input wire [3:0] SRC_REG_IN,
   input wire [3:0] DST_REG_IN,
   input wire [19:0] OPERAND_IN,
   input wire [19:0] MEM_WORD_IN,
   input wire [19:0] PC_IN,
   input wire NMI_ENTRY_IN,
   input wire [19:0] PC_OUT,
   input wire [19:0] SP_OUT,
   input wire [19:0] PUSH_DATA_OUT,
   input wire PUSH_VALID_OUT,
   input wire WIDE_EXEC_OUT,
   input wire FAULT_OUT
);
   default clocking @(posedge CLK_IN);
   endclocking
   default disable iff (RST_IN);
   wire go = INSN_VALID_IN;
   wire [3:0] c = go ? INSN_CLASS_IN : `OP_OTHER;
   wire [19:0] ret = PC_IN + (DEFECT_EN_IN ? 20'h0_0002 : 20'h0_0004);
   wire [19:0] add_res = ret + OPERAND_IN;
   wire [19:0] sp_nxt = DEFECT_EN_IN ? MEM_WORD_IN : SP_OUT - 20'h0_0004;
   wire [19:0] sx_tgt = MEM_WORD_IN + {{4{OPERAND_IN[15]}}, OPERAND_IN[15:0]};
   idle_quiet_a: assert property (!go |=> !PUSH_VALID_OUT && !FAULT_OUT && !WIDE_EXEC_OUT)
      else $error("pulse without instruction");
   add_pc_a: assert property (c == `OP_ADD_ADDR_IMM && DST_REG_IN == `REG_PC |=> PC_OUT == $past(add_res))
      else $error("add to pc wrong");
   move_pc_a: assert property (c == `OP_MOVE_ADDR_IMM && DST_REG_IN == `REG_PC |=> PC_OUT == $past(OPERAND_IN))
      else $error("move to pc wrong");
   call_pc_a: assert property (c == `OP_CALL_ADDR && SRC_MODE_IN == `MODE_REGISTER && SRC_REG_IN == `REG_PC
      |=> PUSH_VALID_OUT && PUSH_DATA_OUT == $past(ret)) else $error("call pc return wrong");
   push_sp_a: assert property (c == `OP_PUSH_EXT_ADDR && SRC_MODE_IN == `MODE_INDIRECT_INC && SRC_REG_IN == `REG_SP
      |=> SP_OUT == $past(sp_nxt)) else $error("push sp wrong");
   sx_other_a: assert property (c == `OP_CALL_ADDR && SRC_MODE_IN == `MODE_INDEXED && SRC_REG_IN != `REG_SP
      |=> PC_OUT == $past(sx_tgt)) else $error("indexed call not sign extended");
   fault_cause_a: assert property (FAULT_OUT |-> $past(DEFECT_EN_IN) && $past(DST_REG_IN) == `REG_PC)
      else $error("fault without cause");
   wide_cause_a: assert property (WIDE_EXEC_OUT |-> $past(NMI_ENTRY_IN) && $past(DEFECT_EN_IN))
      else $error("wide execution without cause");
   cover property (FAULT_OUT);
   cover property (WIDE_EXEC_OUT);
   cover property (PUSH_VALID_OUT);
endmodule
bind cpu_pc_sp_hazard_model pc_sp_checker pc_sp_checker_inst (.*);

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg de = 1'b0;
   reg v = 1'b0;
   reg np = 1'b0;
   reg ne = 1'b0;
   reg [3:0] cl = 4'h0;
   reg [3:0] sr = 4'h0;
   reg [3:0] dr = 4'h0;
   reg [2:0] sm = 3'h0;
   reg [2:0] dm = 3'h0;
   reg [19:0] op = 20'h0_0000;
   reg [19:0] pc = 20'h0_1000;
   reg [19:0] ma = 20'h0_4000;
   reg [19:0] s0;
   wire [19:0] mw, pco, spo, pdo;
   wire pvo, weo, flo;
   integer num_errors = 0;
   integer check_count = 0;
   integer cyc = 0;
   integer d, m, b;
   prog_mem_model prog_mem_model_inst (.addr_in(ma), .word_out(mw));
   cpu_pc_sp_hazard_model cpu_pc_sp_hazard_model_inst (.CLK_IN(clk), .RST_IN(rst), .DEFECT_EN_IN(de),
      .INSN_VALID_IN(v), .INSN_CLASS_IN(cl), .SRC_MODE_IN(sm), .DST_MODE_IN(dm), .SRC_REG_IN(sr), .DST_REG_IN(dr),
      .OPERAND_IN(op), .MEM_WORD_IN(mw), .PC_IN(pc), .NMI_PENDING_IN(np), .NMI_ENTRY_IN(ne), .PC_OUT(pco),
      .SP_OUT(spo), .PUSH_DATA_OUT(pdo), .PUSH_VALID_OUT(pvo), .WIDE_EXEC_OUT(weo), .FAULT_OUT(flo));
   initial
   begin
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 1000)
      begin
         num_errors = num_errors + 1;
         stop_test;
      end
   end
   task stop_test;
   begin
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   end
   endtask
   task chk(input [19:0] got, input [19:0] exp);
   begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
         num_errors = num_errors + 1;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   end
   endtask
   // inputs change 1 ns after the edge; valid stays up for back-to-back issue
   task ins(input [3:0] c, input [2:0] s, input [2:0] t, input [3:0] r, input [3:0] q, input [19:0] o);
   begin
      v = 1'b1;
      cl = c;
      sm = s;
      dm = t;
      sr = r;
      dr = q;
      op = o;
      @(posedge clk);
      #1;
   end
   endtask
   task idle;
   begin
      v = 1'b0;
      @(posedge clk);
      #1;
   end
   endtask
   task t_main;
   begin
      for (d = 0; d < 2; d = d + 1)
      begin
         de = d[0];
         ins(4'h2, 3'h6, 3'h0, 4'h3, 4'h0, 20'h0_0010);
         chk(pco, pc + (d ? 20'h0_0012 : 20'h0_0014));
         ins(4'h3, 3'h6, 3'h0, 4'h3, 4'h0, 20'h0_0010);
         chk(pco, pc + (d ? 20'hF_FFF2 : 20'hF_FFF4));
         ins(4'h4, 3'h6, 3'h0, 4'h3, 4'h0, 20'h0_0010);
         chk(pco, pc + (d ? 20'hF_FFF2 : 20'hF_FFF4));
         ins(4'h5, 3'h6, 3'h0, 4'h3, 4'h0, 20'h0_0010);
         chk(pco, 20'h0_0010);
         s0 = spo;
         ins(4'h6, 3'h5, 3'h0, 4'h1, 4'h1, 20'h0_0000);
         chk(spo, d ? mw : s0 - 20'h0_0004);
         chk(pdo, mw);
         s0 = spo;
         ins(4'h8, 3'h0, 3'h0, 4'h0, 4'h0, 20'h0_0000);
         chk(pdo, pc + (d ? 20'h0_0002 : 20'h0_0004));
         chk(pco, pc + 20'h0_0004);
         chk(pvo, 20'h0_0001);
         chk(spo, s0 - 20'h0_0004);
         idle;
         chk(pvo, 20'h0_0000);
      end
      $display("arith push call done");
   end
   endtask
   // mid-run reset: PC, SP, push data and fault outputs return to zero
   task t_rst;
   begin
      rst = 1'b1;
      @(posedge clk);
      #1;
      chk(pco, 20'h0_0000);
      chk(spo, 20'h0_0000);
      chk(pdo, 20'h0_0000);
      chk(flo, 20'h0_0000);
      rst = 1'b0;
      $display("mid-run reset done");
   end
   endtask
   task t_sx;
   begin
      for (d = 0; d < 2; d = d + 1)
         for (m = 0; m < 7; m = m + 1)
            for (b = 0; b < 2; b = b + 1)
            begin
               de = d[0];
               ins(4'h7, m[2:0], 3'h0, 4'h4, 4'h1, 20'h0_0000);
               ins(4'h8, 3'h1, 3'h0, b ? 4'h1 : 4'h5, 4'h0, 20'h0_FFFE);
               chk(pco, mw + ((d && b && m > 0 && m < 6) ? 20'h0_FFFE : 20'hF_FFFE));
            end
      $display("indexed call done");
   end
   endtask
   task t_seq;
   begin
      for (d = 0; d < 2; d = d + 1)
      begin
         de = d[0];
         for (m = 0; m < 3; m = m + 1)
         begin
            ins(4'h1, 3'h0, m[2:0] + 3'h1, 4'h6, 4'h3, 20'h0_0000);
            ins(4'h1, (m == 2) ? 3'h1 : m[2:0] + 3'h4, 3'h0, 4'h4, 4'h0, 20'h0_0000);
            chk(flo, d[0]);
            if (d == 0)
               chk(pco, mw);
         end
         np = 1'b1;
         ins(4'h9, 3'h1, 3'h0, 4'h2, 4'h0, 20'h0_0000);
         np = 1'b0;
         ins(4'hA, 3'h0, 3'h0, 4'h3, 4'h4, 20'h0_0000);
         ne = 1'b1;
         ins(4'h0, 3'h1, 3'h0, 4'h5, 4'h6, 20'h0_0000);
         ne = 1'b0;
         chk(weo, d[0]);
      end
      $display("sequence faults done");
   end
   endtask
   initial
   begin
      repeat (6) @(posedge clk);
      #1;
      rst = 1'b0;
      t_main;
      t_rst;
      t_sx;
      t_seq;
      stop_test;
   end
endmodule
